// [core/csd_bcd_adjust.sv]
// Packed BCD correction of the working register after an addition
`timescale 1ns/1ps

module csd_bcd_adjust
    import csd_pkg::*;
(
    // Operand and flags
    input  wire logic [7:0] w_in,
    input  wire logic       c_in,
    input  wire logic       dcy_in,
    // Result
    output logic [7:0]      res_out,
    output logic            carry_out
);

    // ========================================================================
    // Nibble correction
    // ========================================================================
    logic       lo_adj;  // Low digit needs fixing
    logic [4:0] lo_sum;  // Low digit with its carry
    logic [4:0] hi_mid;  // High digit plus low carry
    logic       hi_adj;  // High digit needs fixing
    logic [4:0] hi_sum;  // High digit corrected

    // The low carry ripples into the high digit, so the high test
    // looks at the digit after that ripple, not before it
    always_comb
    begin
        lo_adj    = (w_in[3:0] > BCD_MAX) || dcy_in;
        lo_sum    = {1'b0, w_in[3:0]} + (lo_adj ? {1'b0, BCD_FIX} : 5'h00);
        hi_mid    = {1'b0, w_in[7:4]} + {4'h0, lo_sum[4]};
        hi_adj    = (hi_mid > {1'b0, BCD_MAX}) || c_in;
        hi_sum    = hi_mid + (hi_adj ? {1'b0, BCD_FIX} : 5'h00);
        res_out   = {hi_sum[3:0], lo_sum[3:0]};
        carry_out = hi_adj;
    end

endmodule

// [core/csd_exec.sv]
// Execution unit for unsigned compare-and-skip and decimal adjust instructions
`timescale 1ns/1ps

module csd_exec
    import csd_pkg::*;
#(
    parameter logic [DIV_W-1:0] QUARTER_CLKS = DIV_ONE,        // Clocks per quarter
    parameter logic [3:0]       ACCESS_BANK  = ACCESS_BANK_DEF // Bank when access bit is 0
)
(
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        RESET_N_IN,
    // Instruction from the fetch stage
    input  wire logic        INSTR_VALID_IN,
    input  wire logic [15:0] INSTR_IN,
    input  wire logic        NEXT_TWO_WORD_IN,
    // Core state seen by the unit
    input  wire logic [7:0]  FILE_DATA_IN,
    input  wire logic [7:0]  WORK_REG_IN,
    input  wire logic [3:0]  BANK_SEL_IN,
    input  wire logic        CARRY_IN,
    input  wire logic        DIGIT_CARRY_IN,
    // Data memory read
    output logic [11:0]      FILE_ADDR_OUT,
    output logic             FILE_RD_OUT,
    // Working register and carry write back
    output logic             WORK_WR_OUT,
    output logic [7:0]       WORK_DATA_OUT,
    output logic             CARRY_WR_OUT,
    output logic             CARRY_OUT,
    // Sequencing
    output logic [1:0]       QUARTER_OUT,
    output logic             SKIP_NOP_OUT,
    output logic             BUSY_OUT
);

    // ========================================================================
    // State and helpers
    // ========================================================================
    csd_state_s s_reg;    // Registered state
    csd_state_s s_next;   // Next state
    logic       tick;     // One-cycle quarter enable
    csd_op_e    dec_op;   // Decoded operation of INSTR_IN
    logic [7:0] bcd_res;  // Adjusted working register
    logic       bcd_c;    // Adjusted carry

    assign tick = (s_reg.div == '0);

    // Decimal correction datapath
    csd_bcd_adjust u_bcd (
        .w_in      (s_reg.opnd_w),
        .c_in      (s_reg.c_l),
        .dcy_in    (s_reg.dcy_l),
        .res_out   (bcd_res),
        .carry_out (bcd_c)
    );

    // ========================================================================
    // Decode
    // ========================================================================
    // Unknown words decode to none and are left to other units
    always_comb
    begin
        dec_op = OP_NONE;
        if (INSTR_IN == OPC_DECIMAL_ADJ)
        begin
            dec_op = OP_DECIMAL;
        end
        else
        begin
            case (INSTR_IN[OPC_MSB:OPC_LSB])
                OPC_SKIP_GREATER: dec_op = OP_GREATER;
                OPC_SKIP_LESS:    dec_op = OP_LESS;
                OPC_SKIP_EQUAL:   dec_op = OP_EQUAL;
                default:          dec_op = OP_NONE;
            endcase
        end
    end

    // ========================================================================
    // Sequencer
    // ========================================================================
    // All activity happens on the quarter enable; outputs are set at the
    // tick that opens the quarter in which they must be seen
    always_comb
    begin
        s_next = s_reg;
        // Quarter divider
        if (tick)
        begin
            s_next.div = QUARTER_CLKS - DIV_ONE;
            s_next.qph = s_reg.qph + 2'h1;
        end
        else
        begin
            s_next.div = s_reg.div - DIV_ONE;
        end

        if (tick)
        begin
            case (s_reg.qph)
                // End of Q1: take and decode a new word
                PH_Q1:
                begin
                    if (s_reg.st == ST_IDLE && INSTR_VALID_IN && dec_op != OP_NONE)
                    begin
                        s_next.st   = ST_EXEC;
                        s_next.op   = dec_op;
                        s_next.busy = 1'b1;
                        s_next.hit  = 1'b0;
                        // Access bank ignores the bank select value
                        s_next.file_addr = {INSTR_IN[ACC_BIT] ? BANK_SEL_IN : ACCESS_BANK,
                                            INSTR_IN[FILE_MSB:0]};
                        s_next.file_rd   = (dec_op != OP_DECIMAL);
                    end
                end
                // End of Q2: capture operands
                PH_Q2:
                begin
                    s_next.file_rd = 1'b0;
                    if (s_reg.st == ST_EXEC)
                    begin
                        s_next.opnd_f = FILE_DATA_IN;
                        s_next.opnd_w = WORK_REG_IN;
                        s_next.c_l    = CARRY_IN;
                        s_next.dcy_l  = DIGIT_CARRY_IN;
                    end
                end
                // End of Q3: process; only decimal adjust writes anything
                PH_Q3:
                begin
                    if (s_reg.st == ST_EXEC)
                    begin
                        case (s_reg.op)
                            OP_GREATER: s_next.hit = s_reg.opnd_f > s_reg.opnd_w;
                            OP_LESS:    s_next.hit = s_reg.opnd_f < s_reg.opnd_w;
                            OP_EQUAL:   s_next.hit = s_reg.opnd_f == s_reg.opnd_w;
                            OP_DECIMAL:
                            begin
                                s_next.work_wr   = 1'b1;
                                s_next.work_data = bcd_res;
                                s_next.carry_wr  = 1'b1;
                                s_next.carry     = bcd_c;
                            end
                            default:    s_next.hit = 1'b0;
                        endcase
                    end
                end
                // End of Q4: retire or enter the no-op cycles
                PH_Q4:
                begin
                    s_next.work_wr  = 1'b0;
                    s_next.carry_wr = 1'b0;
                    if (s_reg.st == ST_EXEC)
                    begin
                        if (s_reg.hit)
                        begin
                            // Fetched word is dropped; a two-word one costs two cycles
                            s_next.st        = ST_SKIP;
                            s_next.skip_nop  = 1'b1;
                            s_next.skip_left = NEXT_TWO_WORD_IN ? SKIP_TWO_WORD
                                                                : SKIP_ONE_WORD;
                        end
                        else
                        begin
                            s_next.st   = ST_IDLE;
                            s_next.busy = 1'b0;
                        end
                    end
                    else if (s_reg.st == ST_SKIP)
                    begin
                        if (s_reg.skip_left == SKIP_ONE_WORD)
                        begin
                            s_next.st       = ST_IDLE;
                            s_next.skip_nop = 1'b0;
                            s_next.busy     = 1'b0;
                        end
                        else
                        begin
                            s_next.skip_left = s_reg.skip_left - 2'h1;
                        end
                    end
                end
                default:
                begin
                    s_next.qph = PH_Q1;
                end
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge MCLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            s_reg <= STATE_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ========================================================================
    // Outputs, all straight from the state register
    // ========================================================================
    assign FILE_ADDR_OUT = s_reg.file_addr;
    assign FILE_RD_OUT   = s_reg.file_rd;
    assign WORK_WR_OUT   = s_reg.work_wr;
    assign WORK_DATA_OUT = s_reg.work_data;
    assign CARRY_WR_OUT  = s_reg.carry_wr;
    assign CARRY_OUT     = s_reg.carry;
    assign QUARTER_OUT   = s_reg.qph;
    assign SKIP_NOP_OUT  = s_reg.skip_nop;
    assign BUSY_OUT      = s_reg.busy;

    // ========================================================================
    // Checks
    // ========================================================================
    logic [3:0] q_cnt;  // Quarters spent busy, for cycle counting

    always_ff @(posedge MCLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            q_cnt <= 4'h0;
        end
        else if (tick)
        begin
            q_cnt <= s_reg.busy ? q_cnt + 4'h1 : 4'h0;
        end
    end

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    property p_decode_read;
        tick && s_reg.qph == PH_Q1 && s_reg.st == ST_IDLE && INSTR_VALID_IN
        && (INSTR_IN[OPC_MSB:OPC_LSB] == OPC_SKIP_GREATER
            || INSTR_IN[OPC_MSB:OPC_LSB] == OPC_SKIP_LESS)
        |=> FILE_RD_OUT && FILE_ADDR_OUT[7:0] == $past(INSTR_IN[7:0]);
    endproperty
    a_decode_read: assert property (p_decode_read)
        else $error("compare word did not start a file read");

    property p_greater;
        $rose(SKIP_NOP_OUT) && s_reg.op == OP_GREATER |-> s_reg.opnd_f > s_reg.opnd_w;
    endproperty
    a_greater: assert property (p_greater)
        else $error("greater skip without file above working value");

    property p_less;
        $rose(SKIP_NOP_OUT) && s_reg.op == OP_LESS |-> s_reg.opnd_f < s_reg.opnd_w;
    endproperty
    a_less: assert property (p_less)
        else $error("less skip without file below working value");

    property p_skip_quiet;
        (BUSY_OUT && s_reg.op != OP_DECIMAL) || SKIP_NOP_OUT
        |-> !WORK_WR_OUT && !CARRY_WR_OUT;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet)
        else $error("compare or skip cycle wrote a register");

    property p_cycles;
        $fell(BUSY_OUT) |-> (q_cnt == 4'h3 || (s_reg.op != OP_DECIMAL
                              && (q_cnt == 4'h7 || q_cnt == 4'hb)));
    endproperty
    a_cycles: assert property (p_cycles)
        else $error("instruction length not one, two or three cycles");

    property p_read_q2;
        FILE_RD_OUT |-> QUARTER_OUT == PH_Q2 && !SKIP_NOP_OUT;
    endproperty
    a_read_q2: assert property (p_read_q2)
        else $error("file read outside the second quarter");

    property p_bank;
        $rose(FILE_RD_OUT) |-> FILE_ADDR_OUT[11:8] ==
            ($past(INSTR_IN[ACC_BIT]) ? $past(BANK_SEL_IN) : ACCESS_BANK);
    endproperty
    a_bank: assert property (p_bank)
        else $error("wrong bank for file access");

    property p_low_fix;
        WORK_WR_OUT && s_reg.opnd_w[3:0] > BCD_MAX
        |-> WORK_DATA_OUT[3:0] == s_reg.opnd_w[3:0] + BCD_FIX;
    endproperty
    a_low_fix: assert property (p_low_fix)
        else $error("low digit not corrected by six");

    property p_high_carry;
        WORK_WR_OUT && (s_reg.c_l || s_reg.opnd_w[7:4] > BCD_MAX) |-> CARRY_OUT;
    endproperty
    a_high_carry: assert property (p_high_carry)
        else $error("high digit correction did not set carry");

    property p_adjust_q4;
        $rose(WORK_WR_OUT) |-> QUARTER_OUT == PH_Q4 && CARRY_WR_OUT ##1 !WORK_WR_OUT [*1];
    endproperty
    a_adjust_q4: assert property (p_adjust_q4)
        else $error("decimal adjust write not in the fourth quarter");

    c_skip_one: cover property ($fell(BUSY_OUT) && q_cnt == 4'h7);
    c_skip_two: cover property ($fell(BUSY_OUT) && q_cnt == 4'hb);
    c_adjust:   cover property (WORK_WR_OUT && CARRY_OUT);

endmodule

// [shared/csd_pkg.sv]
// Constants, encodings and state layout for the compare-skip and decimal adjust unit
package csd_pkg;

    // ========================================================================
    // Instruction encodings
    // ========================================================================
    localparam logic [6:0]  OPC_SKIP_LESS    = 7'h30;    // 0110 000a
    localparam logic [6:0]  OPC_SKIP_EQUAL   = 7'h31;    // 0110 001a
    localparam logic [6:0]  OPC_SKIP_GREATER = 7'h32;    // 0110 010a
    localparam logic [15:0] OPC_DECIMAL_ADJ  = 16'h0007; // Whole word, no operands

    // Field positions inside the instruction word
    localparam int OPC_MSB  = 15;
    localparam int OPC_LSB  = 9;
    localparam int ACC_BIT  = 8;
    localparam int FILE_MSB = 7;

    // ========================================================================
    // Quarter cycles and timing
    // ========================================================================
    localparam logic [1:0] PH_Q1 = 2'h0; // Decode
    localparam logic [1:0] PH_Q2 = 2'h1; // Read
    localparam logic [1:0] PH_Q3 = 2'h2; // Process
    localparam logic [1:0] PH_Q4 = 2'h3; // Write
    localparam int         DIV_W = 12;   // Width of the quarter divider
    localparam logic [DIV_W-1:0] DIV_ONE = 12'h001;

    // No-op cycles left after a skip
    localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
    localparam logic [1:0] SKIP_TWO_WORD = 2'h2;

    // ========================================================================
    // Packed BCD limits
    // ========================================================================
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;

    // Default bank used when the access bit is clear
    localparam logic [3:0] ACCESS_BANK_DEF = 4'h0;

    // ========================================================================
    // Sequencer states and operation kinds
    // ========================================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_SKIP = 3'b100
    } csd_state_e;

    typedef enum logic [4:0] {
        OP_NONE    = 5'b00001,
        OP_GREATER = 5'b00010,
        OP_LESS    = 5'b00100,
        OP_EQUAL   = 5'b01000,
        OP_DECIMAL = 5'b10000
    } csd_op_e;

    // Whole state of the execution unit
    typedef struct packed {
        csd_state_e       st;        // Sequencer state
        csd_op_e          op;        // Instruction in flight
        logic [1:0]       qph;       // Current quarter
        logic [DIV_W-1:0] div;       // Quarter divider
        logic [7:0]       opnd_f;    // File operand
        logic [7:0]       opnd_w;    // Working register operand
        logic             c_l;       // Carry at read
        logic             dcy_l;     // Digit carry at read
        logic             hit;       // Skip condition met
        logic [1:0]       skip_left; // No-op cycles still to run
        logic [11:0]      file_addr; // Bank and file address
        logic             file_rd;   // File read strobe
        logic             work_wr;   // Working register write
        logic [7:0]       work_data; // Value written back
        logic             carry_wr;  // Carry flag write
        logic             carry;     // New carry value
        logic             skip_nop;  // Fetched word is being discarded
        logic             busy;      // Instruction in progress
    } csd_state_s;

    localparam csd_state_s STATE_RST = '{st: ST_IDLE, op: OP_NONE, default: '0};

endpackage

// [tb/testbench.sv]
// Self-checking bench for the compare-skip and decimal adjust execution unit
`timescale 1ns/1ps

module testbench;
    import csd_pkg::*;

    // ========================================================================
    // Settings
    // ========================================================================
    localparam logic [3:0] ACC_BANK = 4'h5;  // Non-zero so a wrong bank shows
    localparam int         LIMIT    = 20000; // Cycle ceiling for the whole run

    // ========================================================================
    // Signals
    // ========================================================================
    logic        clk;          // Bench clock
    logic        rst_n;        // Synchronous reset, active low
    logic        valid;        // Instruction valid
    logic [15:0] instr;        // Instruction word
    logic        two_word;     // Next word is a two-word instruction
    logic [7:0]  file_data;    // File register operand
    logic [7:0]  work_reg;     // Working register operand
    logic [3:0]  bank_sel;     // Bank select register
    logic        carry_f;      // Carry flag
    logic        dcarry_f;     // Digit carry flag
    logic [11:0] file_addr;    // Observed file address
    logic        file_rd;      // Observed file read
    logic        work_wr;      // Observed working register write
    logic [7:0]  work_data;    // Observed write-back value
    logic        carry_wr;     // Observed carry write
    logic        carry_new;    // Observed new carry
    logic [1:0]  quarter;      // Observed quarter
    logic        skip_nop;     // Observed no-op cycle
    logic        busy;         // Observed busy
    logic [15:0] addr_q[$];    // Expected file addresses
    logic [15:0] adj_q[$];     // Expected carry and adjusted value
    logic [15:0] len_q[$];     // Expected busy and no-op cycle counts
    int          bad_count;    // Mismatches
    int          compares;     // Comparisons made
    int          cyc;          // Cycle counter for the timeout
    int          seed;         // Random seed
    logic [7:0]  bcnt;         // Busy cycles of the current instruction
    logic [7:0]  ncnt;         // No-op cycles of the current instruction
    logic        prev_busy;    // Busy at the previous sample

    // ========================================================================
    // Device under test
    // ========================================================================
    csd_exec #(
        .QUARTER_CLKS (DIV_ONE),
        .ACCESS_BANK  (ACC_BANK)
    ) u_dut (
        .MCLK_IN          (clk),
        .RESET_N_IN       (rst_n),
        .INSTR_VALID_IN   (valid),
        .INSTR_IN         (instr),
        .NEXT_TWO_WORD_IN (two_word),
        .FILE_DATA_IN     (file_data),
        .WORK_REG_IN      (work_reg),
        .BANK_SEL_IN      (bank_sel),
        .CARRY_IN         (carry_f),
        .DIGIT_CARRY_IN   (dcarry_f),
        .FILE_ADDR_OUT    (file_addr),
        .FILE_RD_OUT      (file_rd),
        .WORK_WR_OUT      (work_wr),
        .WORK_DATA_OUT    (work_data),
        .CARRY_WR_OUT     (carry_wr),
        .CARRY_OUT        (carry_new),
        .QUARTER_OUT      (quarter),
        .SKIP_NOP_OUT     (skip_nop),
        .BUSY_OUT         (busy)
    );

    // ========================================================================
    // Clock and timeout
    // ========================================================================
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short; counts as a mismatch
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            results();
        end
    end

    // ========================================================================
    // Shared tasks
    // ========================================================================
    // Single compare for every kind of result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One compare per kind of result, all counted by chk
    task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
        chk(got, exp);
    endtask

    task automatic chk_adj(input logic [15:0] got, input logic [15:0] exp);
        chk(got, exp);
    endtask

    task automatic chk_len(input logic [15:0] got, input logic [15:0] exp);
        chk(got, exp);
    endtask

    // Verdict and end of run
    task automatic results();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Packed BCD correction, high digit tested after the low carry ripples
    function automatic logic [15:0] adj_exp(input logic [7:0] w, input logic c, dcy);
        logic [8:0] s;
        logic       hi;
        s = {1'b0, w};
        if (w[3:0] > BCD_MAX || dcy)
            s = s + {5'h0, BCD_FIX};
        // Bit 8 keeps the ripple out of a high digit of fifteen
        hi = (s[8:4] > {1'b0, BCD_MAX}) || c;
        if (hi)
            s = s + {1'b0, BCD_FIX, 4'h0};
        return {7'h0, hi, s[7:0]};
    endfunction

    // Presents one word, holds operands until the unit goes idle again
    task automatic run_op(input logic [15:0] word, input logic [7:0] fd, wd,
                          input logic [3:0] bs, input logic cf, dcf, tw);
        int n;
        @(posedge clk);
        instr     <= word;
        valid     <= 1'b1;
        file_data <= fd;
        work_reg  <= wd;
        bank_sel  <= bs;
        carry_f   <= cf;
        dcarry_f  <= dcf;
        two_word  <= tw;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (busy !== 1'b1 && n < 20);
        @(posedge clk);
        valid <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // ========================================================================
    // Output watcher, samples at the falling edge where outputs are settled
    // ========================================================================
    always @(negedge clk)
    begin
        if (rst_n === 1'b1)
        begin
            // File read of a compare
            if (file_rd === 1'b1)
            begin
                if (addr_q.size() == 0)
                    chk(16'h0001, 16'h0000); // Unexpected read
                else
                    chk_addr({4'h0, file_addr}, addr_q.pop_front()); // Bank, address
                chk({14'h0, quarter}, {14'h0, PH_Q2}); // Read in second quarter
            end
            // Working register write of a decimal adjust
            if (work_wr === 1'b1)
            begin
                if (adj_q.size() == 0)
                    chk(16'h0002, 16'h0000); // Compare must not write
                else
                    chk_adj({7'h0, carry_new, work_data}, adj_q.pop_front());
                chk({13'h0, carry_wr, quarter}, {13'h0, 1'b1, PH_Q4}); // Q4 write
            end
            // No-op cycles only inside an instruction
            if (skip_nop === 1'b1 && busy !== 1'b1)
                chk(16'h0003, 16'h0000); // Stray no-op
            if (busy === 1'b1)
                bcnt++;
            if (skip_nop === 1'b1)
                ncnt++;
            if (prev_busy === 1'b1 && busy === 1'b0)
            begin
                if (len_q.size() == 0)
                    chk(16'h0004, 16'h0000); // Unexpected instruction
                else
                    chk_len({bcnt, ncnt}, len_q.pop_front()); // Cycle count
                bcnt = 8'h00;
                ncnt = 8'h00;
            end
            prev_busy = busy;
        end
    end

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial
    begin : main
        logic [6:0] opc [3];
        logic [7:0] f;
        logic [7:0] w;
        logic [3:0] bs;
        logic       a;
        logic       tw;
        logic       c;
        logic       dcy;
        logic       hit;
        logic [15:0] bad_words [4];
        opc = '{OPC_SKIP_GREATER, OPC_SKIP_LESS, OPC_SKIP_EQUAL};
        bad_words = '{16'h6600, 16'h0006, 16'h0107, 16'h6a00};
        seed = 32'h89d5;
        bad_count = 0;
        compares = 0;
        cyc = 0;
        bcnt = 8'h00;
        ncnt = 8'h00;
        prev_busy = 1'b0;
        rst_n = 1'b0;
        valid = 1'b0;
        instr = 16'h0000;
        two_word = 1'b0;
        file_data = 8'h00;
        work_reg = 8'h00;
        bank_sel = 4'h0;
        carry_f = 1'b0;
        dcarry_f = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Compare variants over above, equal and below, with an ff to 00 wrap and a zero working value
        for (int k = 0; k < 3; k++)
        begin
            for (int n = 0; n < 16; n++)
            begin
                w = (n == 4) ? 8'hff : (n == 8) ? 8'h00 : 8'($random(seed));
                case (n % 4)
                    0: f = w + 8'h01;
                    1: f = w;
                    2: f = w - 8'h01;
                    default: f = 8'($random(seed));
                endcase
                a = n[0];
                tw = n[2];
                bs = 4'($random(seed));
                hit = (k == 0) ? (f > w) : (k == 1) ? (f < w) : (f == w);
                addr_q.push_back({4'h0, a ? bs : ACC_BANK, f});
                len_q.push_back(!hit ? 16'h0300 : tw ? 16'h0b08 : 16'h0704);
                run_op({opc[k], a, f}, f, w, bs, 1'b0, 1'b0, tw);
            end
            $display("test compare variant %0d done", k);
        end
        // Decimal adjust: the two worked values, a ripple case, then random operands
        for (int n = 0; n < 24; n++)
        begin
            // Third value makes the low carry ripple into a high digit of fifteen
            w = (n == 0) ? 8'ha5 : (n == 1) ? 8'hce : (n == 2) ? 8'hfa : 8'($random(seed));
            c = (n < 2) ? 1'b0 : 1'($random(seed));
            dcy = (n < 2) ? 1'b0 : 1'($random(seed));
            adj_q.push_back(adj_exp(w, c, dcy));
            len_q.push_back(16'h0300); // Single cycle
            run_op(OPC_DECIMAL_ADJ, 8'($random(seed)), w, 4'h0, c, dcy, 1'b0);
        end
        $display("test decimal adjust done");
        // Unknown words and an invalid word are ignored
        for (int n = 0; n < 5; n++)
        begin
            @(posedge clk);
            instr <= (n < 4) ? bad_words[n] : {OPC_SKIP_GREATER, 1'b1, 8'h10};
            valid <= (n < 4);
            repeat (8)
            begin
                @(negedge clk);
                chk({13'h0, busy, file_rd, work_wr}, 16'h0000); // Not taken
            end
        end
        @(posedge clk);
        valid <= 1'b0;
        repeat (4) @(posedge clk);
        chk(16'(addr_q.size() + adj_q.size() + len_q.size()), 16'h0000); // All seen
        $display("test ignored words done");
        results();
    end

endmodule
